// ### core/mad_pkg.sv
package mad_pkg;
    localparam int WORD_W = 16;
    localparam int LONG_W = 32;
    localparam int GUARD_W = 8;
    localparam int ACC_W = LONG_W + GUARD_W;
    localparam int NUM_ALU = 4;
    localparam int SHIFT_ACC = 16;
    localparam int SCALE_LSB = 0;
    localparam int SCALE_W = 2;
    localparam logic [ACC_W-1:0] ACC_RESET = 40'h00_0000_0000;
    localparam logic [LONG_W-1:0] PROD_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        MAD_SCALE_NONE,
        MAD_SCALE_DOWN,
        MAD_SCALE_UP,
        MAD_SCALE_RSV
    } mad_scale_t;

    typedef enum logic [4:0] {
        MAD_OP_NOP,
        MAD_OP_ADD,
        MAD_OP_SUB,
        MAD_OP_AND,
        MAD_OP_OR,
        MAD_OP_EOR,
        MAD_OP_MPYSS,
        MAD_OP_MPYSU,
        MAD_OP_MPYUS,
        MAD_OP_MPYUU,
        MAD_OP_MACSS,
        MAD_OP_MACSU,
        MAD_OP_MACUS,
        MAD_OP_MACUU,
        MAD_OP_DMACSS,
        MAD_OP_DMACSU,
        MAD_OP_DIV,
        MAD_OP_SAT,
        MAD_OP_RND,
        MAD_OP_LOW
    } mad_op_t;

    typedef struct packed {
        logic valid;
        mad_op_t op;
        logic [LONG_W-1:0] src_a;
        logic [LONG_W-1:0] src_b;
    } mad_instr_t;

    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic [LONG_W-1:0] low;
        logic overflow;
        logic limited;
    } mad_result_t;
endpackage : mad_pkg

// ### core/mad_datapath.sv
`timescale 1ns/1ps
module mad_datapath #(
    parameter int NUM_ALU = mad_pkg::NUM_ALU
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [15:0] core_status_word,
    input wire mad_pkg::mad_instr_t instr [NUM_ALU],
    output mad_pkg::mad_result_t result [NUM_ALU]
);
    localparam int AW = mad_pkg::ACC_W;
    localparam int LW = mad_pkg::LONG_W;
    localparam int WW = mad_pkg::WORD_W;

    logic [AW-1:0] acc [NUM_ALU];
    logic [LW-1:0] low [NUM_ALU];
    logic ovf [NUM_ALU];
    logic lim [NUM_ALU];
    logic [AW-1:0] next_acc [NUM_ALU];
    logic [LW-1:0] next_low [NUM_ALU];
    logic next_ovf [NUM_ALU];
    logic next_lim [NUM_ALU];
    mad_pkg::mad_scale_t scale;

    assign scale = mad_pkg::mad_scale_t'(
        core_status_word[mad_pkg::SCALE_LSB +: mad_pkg::SCALE_W]);

    // one product of two 16-bit halves with chosen signedness
    function automatic logic [AW-1:0] mul16(input logic [WW-1:0] a, input logic sa,
                                            input logic [WW-1:0] b, input logic sb);
        logic signed [WW:0] ea;
        logic signed [WW:0] eb;
        logic signed [2*WW+1:0] p;
        ea = {sa & a[WW-1], a};
        eb = {sb & b[WW-1], b};
        p = ea * eb;
        return {{(AW-2*WW-2){p[2*WW+1]}}, p};
    endfunction : mul16

    function automatic logic [AW-1:0] scale_acc(input logic [AW-1:0] v,
                                                input mad_pkg::mad_scale_t s);
        logic [AW-1:0] r;
        r = v;
        unique case (s)
            mad_pkg::MAD_SCALE_DOWN: r = {v[AW-1], v[AW-1:1]};
            mad_pkg::MAD_SCALE_UP: r = {v[AW-2:0], 1'b0};
            mad_pkg::MAD_SCALE_NONE, mad_pkg::MAD_SCALE_RSV: r = v;
        endcase
        return r;
    endfunction : scale_acc

    // overflow when the value does not fit a signed 32-bit long (16.16 fraction)
    function automatic logic beyond16(input logic [AW-1:0] v);
        return (v[AW-1:LW-1] != {(AW-LW+1){1'b0}}) && (v[AW-1:LW-1] != {(AW-LW+1){1'b1}});
    endfunction : beyond16

    always_comb begin
        for (int i = 0; i < NUM_ALU; i++) begin
            logic [AW-1:0] a40;
            logic [AW-1:0] b40;
            logic [AW-1:0] sum;
            logic [AW-1:0] shr;
            logic [AW-1:0] rnd;
            logic [AW-1:0] qt;
            logic [WW-1:0] ah;
            logic [WW-1:0] bh;
            a40 = '0;
            b40 = '0;
            sum = '0;
            shr = '0;
            rnd = '0;
            qt = '0;
            ah = instr[i].src_a[WW-1:0];
            bh = instr[i].src_b[WW-1:0];
            a40 = {{(AW-LW){instr[i].src_a[LW-1]}}, instr[i].src_a};
            b40 = {{(AW-LW){instr[i].src_b[LW-1]}}, instr[i].src_b};
            shr = {{mad_pkg::SHIFT_ACC{acc[i][AW-1]}},
                   acc[i][AW-1:mad_pkg::SHIFT_ACC]};
            next_acc[i] = acc[i];
            next_low[i] = low[i];
            next_ovf[i] = ovf[i];
            next_lim[i] = 1'b0;
            sum = acc[i];
            if (instr[i].valid) begin
                unique case (instr[i].op)
                    mad_pkg::MAD_OP_NOP: sum = acc[i];
                    mad_pkg::MAD_OP_ADD: sum = a40 + b40;
                    mad_pkg::MAD_OP_SUB: sum = a40 - b40;
                    mad_pkg::MAD_OP_AND: sum = {{(AW-LW){1'b0}}, instr[i].src_a & instr[i].src_b};
                    mad_pkg::MAD_OP_OR: sum = {{(AW-LW){1'b0}}, instr[i].src_a | instr[i].src_b};
                    mad_pkg::MAD_OP_EOR: sum = {{(AW-LW){1'b0}}, instr[i].src_a ^ instr[i].src_b};
                    mad_pkg::MAD_OP_MPYSS: sum = mul16(ah, 1'b1, bh, 1'b1);
                    mad_pkg::MAD_OP_MPYSU: sum = mul16(ah, 1'b1, bh, 1'b0);
                    mad_pkg::MAD_OP_MPYUS: sum = mul16(ah, 1'b0, bh, 1'b1);
                    mad_pkg::MAD_OP_MPYUU: sum = mul16(ah, 1'b0, bh, 1'b0);
                    mad_pkg::MAD_OP_MACSS: sum = acc[i] + mul16(ah, 1'b1, bh, 1'b1);
                    mad_pkg::MAD_OP_MACSU: sum = acc[i] + mul16(ah, 1'b1, bh, 1'b0);
                    mad_pkg::MAD_OP_MACUS: sum = acc[i] + mul16(ah, 1'b0, bh, 1'b1);
                    mad_pkg::MAD_OP_MACUU: sum = acc[i] + mul16(ah, 1'b0, bh, 1'b0);
                    mad_pkg::MAD_OP_DMACSS: sum = shr + mul16(ah, 1'b1, bh, 1'b1);
                    mad_pkg::MAD_OP_DMACSU: sum = shr + mul16(ah, 1'b1, bh, 1'b0);
                    mad_pkg::MAD_OP_DIV: begin
                        // one restoring-free step: shift in a quotient bit
                        qt = {acc[i][AW-2:0], 1'b0};
                        if (qt[AW-1:WW] >= {{(AW-2*WW){1'b0}}, bh}) begin
                            sum = {qt[AW-1:WW] - {{(AW-2*WW){1'b0}}, bh},
                                   qt[WW-1:1], 1'b1};
                        end else begin
                            sum = qt;
                        end
                    end
                    mad_pkg::MAD_OP_SAT: begin
                        sum = acc[i];
                        if (beyond16(acc[i])) begin
                            sum = acc[i][AW-1] ? {{(AW-LW+1){1'b1}}, {(LW-1){1'b0}}}
                                               : {{(AW-LW+1){1'b0}}, {(LW-1){1'b1}}};
                            next_lim[i] = 1'b1;
                        end
                    end
                    mad_pkg::MAD_OP_RND: begin
                        // round to nearest at the 16-bit boundary
                        rnd = acc[i] + {{(AW-WW){1'b0}}, 1'b1, {(WW-1){1'b0}}};
                        sum = {rnd[AW-1:WW], {WW{1'b0}}};
                    end
                    mad_pkg::MAD_OP_LOW: begin
                        // low product half saved before a shifted mac drops it
                        next_low[i] = {acc[i][WW-1:0], low[i][LW-1:WW]};
                        sum = acc[i];
                    end
                    default: sum = acc[i];
                endcase
                if (instr[i].op inside {mad_pkg::MAD_OP_MPYSS, mad_pkg::MAD_OP_MPYSU,
                                        mad_pkg::MAD_OP_MPYUS, mad_pkg::MAD_OP_MPYUU,
                                        mad_pkg::MAD_OP_MACSS, mad_pkg::MAD_OP_MACSU,
                                        mad_pkg::MAD_OP_MACUS, mad_pkg::MAD_OP_MACUU,
                                        mad_pkg::MAD_OP_DMACSS, mad_pkg::MAD_OP_DMACSU}) begin
                    sum = scale_acc(sum, scale);
                end
                next_acc[i] = sum;
                next_ovf[i] = ovf[i] | beyond16(sum);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < NUM_ALU; i++) begin
            if (!nrst) begin
                acc[i] <= mad_pkg::ACC_RESET;
                low[i] <= mad_pkg::PROD_RESET;
                ovf[i] <= 1'b0;
                lim[i] <= 1'b0;
            end else begin
                acc[i] <= next_acc[i];
                low[i] <= next_low[i];
                ovf[i] <= next_ovf[i];
                lim[i] <= next_lim[i];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_ALU; i++) begin
            result[i].acc = acc[i];
            result[i].low = low[i];
            result[i].overflow = ovf[i];
            result[i].limited = lim[i];
        end
    end

    generate
        for (genvar g = 0; g < NUM_ALU; g++) begin : g_chk
            a_add_one_cycle: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_ADD |=>
                acc[g] == $past(a40_of(instr[g].src_a)) + $past(a40_of(instr[g].src_b)))
                else $error("long add result wrong");
            a_sub_one_cycle: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_SUB |=>
                acc[g] == $past(a40_of(instr[g].src_a)) - $past(a40_of(instr[g].src_b)))
                else $error("long subtract result wrong");
            a_mpyuu_value: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_MPYUU &&
                core_status_word[1:0] == 2'h0 |=>
                acc[g][31:0] == $past(instr[g].src_a[15:0]) * $past(instr[g].src_b[15:0]))
                else $error("unsigned multiply wrong");
            a_mpy_single: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_MPYSS &&
                core_status_word[1:0] == 2'h0 |=>
                acc[g] == mul16($past(instr[g].src_a[15:0]), 1'b1,
                                $past(instr[g].src_b[15:0]), 1'b1))
                else $error("signed multiply not one cycle");
            a_dmac_shift: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_DMACSS &&
                core_status_word[1:0] == 2'h0 && instr[g].src_b[15:0] == 16'h0000 |=>
                acc[g] == {{16{$past(acc[g][39])}}, $past(acc[g][39:16])})
                else $error("shifted mac did not shift by sixteen");
            a_sat_limit: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_SAT && beyond16(acc[g]) |=>
                lim[g] && acc[g][39:31] == {9{acc[g][39]}})
                else $error("saturation did not limit");
            a_ovf_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
                ovf[g] |=> ovf[g])
                else $error("overflow flag dropped");
            a_scale_down: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_MPYUU &&
                core_status_word[1:0] == 2'h1 |=>
                acc[g][30:0] == 31'(({16'h0000, $past(instr[g].src_a[15:0])} *
                                     {16'h0000, $past(instr[g].src_b[15:0])}) >> 1))
                else $error("scaling mode not applied");
            a_nop_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
                !instr[g].valid |=> $stable(acc[g]))
                else $error("idle alu changed its accumulator");
            // logic results are zero-extended, never sign-extended
            a_and_logic: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_AND |=>
                acc[g] == {8'h00, $past(instr[g].src_a) & $past(instr[g].src_b)})
                else $error("long and result wrong");
            a_or_logic: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_OR |=>
                acc[g] == {8'h00, $past(instr[g].src_a) | $past(instr[g].src_b)})
                else $error("long or result wrong");
            a_eor_logic: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_EOR |=>
                acc[g] == {8'h00, $past(instr[g].src_a) ^ $past(instr[g].src_b)})
                else $error("long exclusive or result wrong");
            a_mpysu_value: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_MPYSU &&
                core_status_word[1:0] == 2'h0 |=>
                $signed(acc[g]) == $signed($past(instr[g].src_a[15:0])) *
                                   $signed({1'b0, $past(instr[g].src_b[15:0])}))
                else $error("signed by unsigned multiply wrong");
            a_mpyus_value: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_MPYUS &&
                core_status_word[1:0] == 2'h0 |=>
                $signed(acc[g]) == $signed({1'b0, $past(instr[g].src_a[15:0])}) *
                                   $signed($past(instr[g].src_b[15:0])))
                else $error("unsigned by signed multiply wrong");
            a_mac_accum: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_MACSS &&
                core_status_word[1:0] == 2'h0 |=>
                $signed(acc[g]) == $signed($past(acc[g])) +
                    $signed($past(instr[g].src_a[15:0])) * $signed($past(instr[g].src_b[15:0])))
                else $error("signed mac did not accumulate");
            a_div_bit: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_DIV |=>
                acc[g][0] == ($past(acc[g][38:15]) >= {8'h00, $past(instr[g].src_b[15:0])}))
                else $error("divide step quotient bit wrong");
            a_div_shift: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_DIV |=>
                acc[g][15:1] == $past(acc[g][14:0]))
                else $error("divide step did not shift");
            a_rnd_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_RND |=>
                acc[g][15:0] == 16'h0000)
                else $error("rounding left low bits");
            a_rnd_value: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_RND |=>
                acc[g][39:16] == $past(acc[g][39:16]) + $past(acc[g][15]))
                else $error("rounding to nearest wrong");
            a_low_push: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_LOW |=>
                low[g][31:16] == $past(acc[g][15:0]) && low[g][15:0] == $past(low[g][31:16])
                && $stable(acc[g]))
                else $error("low half not saved");
            a_lim_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
                lim[g] |-> $past(instr[g].valid && instr[g].op == mad_pkg::MAD_OP_SAT))
                else $error("limit flag without saturation");
            a_sat_inrange: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_SAT &&
                acc[g][39:31] == {9{acc[g][39]}} |=>
                $stable(acc[g]) && !lim[g])
                else $error("saturation changed an in-range value");
            a_scale_up: assert property (@(posedge ref_clk) disable iff (!nrst)
                instr[g].valid && instr[g].op == mad_pkg::MAD_OP_MPYUU &&
                core_status_word[1:0] == 2'h2 |=>
                acc[g][32:1] == {16'h0000, $past(instr[g].src_a[15:0])} *
                                {16'h0000, $past(instr[g].src_b[15:0])} && !acc[g][0])
                else $error("scale up not applied");
            // checked through reset, so no disable here
            a_reset_clear: assert property (@(posedge ref_clk)
                !nrst |=> acc[g] == mad_pkg::ACC_RESET && low[g] == mad_pkg::PROD_RESET &&
                !ovf[g] && !lim[g])
                else $error("reset did not clear alu state");
        end
    endgenerate

    function automatic logic [AW-1:0] a40_of(input logic [LW-1:0] v);
        return {{(AW-LW){v[LW-1]}}, v};
    endfunction : a40_of
endmodule : mad_datapath

// ### verification/mad_seq_model.sv
`timescale 1ns/1ps
module mad_seq_model #(
    parameter int NUM_ALU = mad_pkg::NUM_ALU
) (
    input wire logic ref_clk,
    output logic [15:0] core_status_word,
    output mad_pkg::mad_instr_t instr [NUM_ALU]
);
    mad_pkg::mad_instr_t stage [NUM_ALU];
    logic [15:0] stage_csw;

    initial begin
        core_status_word = 16'h0000;
        stage_csw = 16'h0000;
        for (int i = 0; i < NUM_ALU; i++) begin
            instr[i] = '0;
            stage[i] = '0;
        end
    end

    // queue one operation for one alu in the next issue cycle
    task automatic put(input int alu, input mad_pkg::mad_op_t op, input logic [31:0] a,
                       input logic [31:0] b);
        stage[alu] = '{valid: 1'b1, op: op, src_a: a, src_b: b};
    endtask : put

    task automatic scale(input mad_pkg::mad_scale_t s);
        stage_csw = {14'h0000, s};
    endtask : scale

    // launch the staged bundle just after the edge; an empty stage idles every alu
    task automatic step();
        @(posedge ref_clk);
        core_status_word <= stage_csw;
        for (int i = 0; i < NUM_ALU; i++) begin
            instr[i] <= stage[i];
            stage[i] = '0;
        end
    endtask : step
endmodule : mad_seq_model

// ### verification/mad_datapath_tb.sv
`timescale 1ns/1ps
module mad_datapath_tb;
    logic ref_clk;
    logic nrst;
    logic [15:0] core_status_word;
    mad_pkg::mad_instr_t instr [4];
    mad_pkg::mad_result_t result [4];
    int err_total;
    int check_count;
    logic [31:0] ta [4];
    logic [31:0] tb [4];
    logic [63:0] pv;

    mad_datapath u_mad_datapath (.ref_clk(ref_clk), .nrst(nrst),
        .core_status_word(core_status_word), .instr(instr), .result(result));
    mad_seq_model u_mad_seq_model (.ref_clk(ref_clk),
        .core_status_word(core_status_word), .instr(instr));

    always #5 ref_clk = ~ref_clk;

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic acc(input int i, input logic [39:0] e);
        check("acc", {24'h000000, result[i].acc}, {24'h000000, e});
    endtask : acc

    task automatic op(input int i, input mad_pkg::mad_op_t o, input logic [31:0] a,
                      input logic [31:0] b);
        u_mad_seq_model.put(i, o, a, b);
    endtask : op

    // two more edges issue any staged bundle and let the last issued one land in the result registers
    task automatic settle();
        u_mad_seq_model.step();
        u_mad_seq_model.step();
        #1;
    endtask : settle

    // all n alus run one long-multiply step on halves of ta and tb
    task automatic bundle(input mad_pkg::mad_op_t o, input bit ha, input bit hb, input int n);
        for (int i = 0; i < n; i++) begin
            op(i, o, {16'h0000, ha ? ta[i][31:16] : ta[i][15:0]},
               {16'h0000, hb ? tb[i][31:16] : tb[i][15:0]});
        end
        u_mad_seq_model.step();
    endtask : bundle

    task automatic test_reset();
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        #1;
        for (int i = 0; i < 4; i++) begin
            acc(i, 40'h00_0000_0000);
            check("flags", {62'h0, result[i].overflow, result[i].limited}, 64'h0);
        end
        $display("test reset done");
    endtask : test_reset

    task automatic test_long_ops();
        for (int i = 0; i < 4; i++) begin
            op(i, mad_pkg::mad_op_t'(mad_pkg::MAD_OP_ADD + i), 32'h7fff_ffff, 32'h0000_0001);
        end
        u_mad_seq_model.step();
        op(2, mad_pkg::MAD_OP_EOR, 32'h7fff_ffff, 32'h0000_0001);
        u_mad_seq_model.step();
        op(0, mad_pkg::MAD_OP_SAT, 32'h0, 32'h0);
        settle();
        acc(0, 40'h00_7fff_ffff);
        check("limited", {63'h0, result[0].limited}, 64'h1);
        check("overflow", {63'h0, result[0].overflow}, 64'h1);
        acc(1, 40'h00_7fff_fffe);
        check("overflow", {63'h0, result[1].overflow}, 64'h0);
        acc(2, 40'h00_7fff_fffe);
        acc(3, 40'h00_7fff_ffff);
        @(posedge ref_clk);
        #1;
        check("limited", {63'h0, result[0].limited}, 64'h0);
        op(1, mad_pkg::MAD_OP_ADD, 32'h8000_0000, 32'hffff_ffff);
        op(3, mad_pkg::MAD_OP_ADD, 32'h0001_8000, 32'h0000_0000);
        u_mad_seq_model.step();
        settle();
        acc(1, 40'hff_7fff_ffff);
        op(1, mad_pkg::MAD_OP_SAT, 32'h0, 32'h0);
        op(3, mad_pkg::MAD_OP_RND, 32'h0, 32'h0);
        settle();
        acc(1, 40'hff_8000_0000);
        acc(3, 40'h00_0002_0000);
        $display("test long ops done");
    endtask : test_long_ops

    task automatic test_mult();
        for (int s = 0; s < 4; s++) begin
            u_mad_seq_model.scale(mad_pkg::mad_scale_t'(s));
            op(s, mad_pkg::MAD_OP_MPYSS, 32'habcd_0003, 32'h1234_fffe);
            u_mad_seq_model.step();
        end
        u_mad_seq_model.scale(mad_pkg::MAD_SCALE_NONE);
        settle();
        acc(0, 40'hff_ffff_fffa);
        acc(1, 40'hff_ffff_fffd);
        acc(2, 40'hff_ffff_fff4);
        acc(3, 40'hff_ffff_fffa);
        op(0, mad_pkg::MAD_OP_MPYSU, 32'h0000_fffe, 32'h0000_0003);
        op(1, mad_pkg::MAD_OP_MPYUS, 32'h0000_0003, 32'h0000_fffe);
        op(2, mad_pkg::MAD_OP_MPYUU, 32'h0000_fffe, 32'h0000_fffe);
        op(3, mad_pkg::MAD_OP_MPYSS, 32'h0000_fffe, 32'h0000_fffe);
        u_mad_seq_model.step();
        op(0, mad_pkg::MAD_OP_MACSU, 32'h0000_fffe, 32'h0000_0003);
        op(2, mad_pkg::MAD_OP_MACUU, 32'h0000_fffe, 32'h0000_0002);
        settle();
        acc(0, 40'hff_ffff_fff4);
        acc(1, 40'hff_ffff_fffa);
        acc(2, 40'h00_fffe_0000);
        acc(3, 40'h00_0000_0004);
        u_mad_seq_model.scale(mad_pkg::MAD_SCALE_DOWN);
        op(3, mad_pkg::MAD_OP_MPYUU, 32'h0000_fffe, 32'h0000_fffe);
        u_mad_seq_model.step();
        u_mad_seq_model.scale(mad_pkg::MAD_SCALE_NONE);
        settle();
        acc(3, 40'h00_7ffe_0002);
        $display("test multiply done");
    endtask : test_mult

    task automatic test_long_mult();
        ta = '{32'h8000_0003, 32'h1234_5678, 32'hffff_ffff, 32'h7fff_fffe};
        tb = '{32'h7fff_fffe, 32'hfedc_ba98, 32'h0000_0002, 32'h8000_0001};
        bundle(mad_pkg::MAD_OP_MPYUU, 0, 0, 4);
        bundle(mad_pkg::MAD_OP_DMACSU, 1, 0, 4);
        bundle(mad_pkg::MAD_OP_MACUS, 0, 1, 4);
        bundle(mad_pkg::MAD_OP_DMACSS, 1, 1, 4);
        settle();
        for (int i = 0; i < 4; i++) begin
            pv = longint'($signed(ta[i])) * longint'($signed(tb[i]));
            acc(i, {{8{pv[63]}}, pv[63:32]});
        end
        bundle(mad_pkg::MAD_OP_MPYUU, 0, 0, 1);
        bundle(mad_pkg::MAD_OP_LOW, 0, 0, 1);
        bundle(mad_pkg::MAD_OP_DMACSU, 1, 0, 1);
        bundle(mad_pkg::MAD_OP_MACUS, 0, 1, 1);
        bundle(mad_pkg::MAD_OP_LOW, 0, 0, 1);
        bundle(mad_pkg::MAD_OP_DMACSS, 1, 1, 1);
        settle();
        pv = longint'($signed(ta[0])) * longint'($signed(tb[0]));
        check("product", {result[0].acc[31:0], result[0].low}, pv);
        ta[0] = 32'h1234_5678;
        op(0, mad_pkg::MAD_OP_MPYSU, 32'h0000_fffd, {16'h0000, ta[0][15:0]});
        u_mad_seq_model.step();
        op(0, mad_pkg::MAD_OP_DMACSS, {16'h0000, ta[0][31:16]}, 32'h0000_fffd);
        settle();
        pv = longint'($signed(ta[0])) * -64'sd3;
        acc(0, {{8{pv[47]}}, pv[47:16]});
        $display("test long multiply done");
    endtask : test_long_mult

    task automatic test_div();
        op(3, mad_pkg::MAD_OP_ADD, 32'h0000_03e8, 32'h0000_0000);
        u_mad_seq_model.step();
        for (int k = 0; k < 16; k++) begin
            op(3, mad_pkg::MAD_OP_DIV, 32'h0000_0000, 32'h0000_0007);
            u_mad_seq_model.step();
        end
        settle();
        acc(3, 40'h00_0006_008e);
        $display("test divide done");
    endtask : test_div

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    initial begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        err_total = 0;
        check_count = 0;
        test_reset();
        test_long_ops();
        test_mult();
        test_long_mult();
        test_div();
        test_reset();
        conclude();
    end

    initial begin
        repeat (3000) @(posedge ref_clk);
        err_total++;
        conclude();
    end
endmodule : mad_datapath_tb
